/* File: cgc_params.svh */
// Contract
// - Offset upper word at 0x2D, reset zero
// - Offset low byte in 0x2E upper byte
// - Gain upper word at 0x2F, read-write
// - Gain low byte in 0x30, reset zero
// - Gain upper word resets to 0x8000
// - Checksum at 0x3E, read-only, reset zero
`ifndef CGC_PARAMS_SVH
`define CGC_PARAMS_SVH
`define CGC_ADDR_OFS_HI 6'h2D
`define CGC_ADDR_OFS_LO 6'h2E
`define CGC_ADDR_GAIN_HI 6'h2F
`define CGC_ADDR_GAIN_LO 6'h30
`define CGC_ADDR_CHECKSUM 6'h3E
`define CGC_ADDR_RSVD 6'h3F
`define CGC_RST_OFS_HI 16'h0000
`define CGC_RST_OFS_LO 8'h00
`define CGC_RST_GAIN_HI 16'h8000
`define CGC_RST_GAIN_LO 8'h00
`define CGC_RST_CHECKSUM 16'h0000
`define CGC_RST_RSVD 16'h0000
`define CGC_RST_RDATA 16'h0000
`define CGC_LOW_PAD 8'h00
`define CGC_UNMAPPED_READ 16'h0000
`define CGC_LOW_FIELD_MSB 15
`define CGC_LOW_FIELD_LSB 8
`define CGC_CRC_POLY 16'h1021
`define CGC_CRC_SEED 16'hFFFF
`endif

/* File: cgc_pkg.sv */
package cgc_pkg;
    typedef struct packed {
        logic [15:0] ofs_hi;
        logic [7:0] ofs_lo;
        logic [15:0] gain_hi;
        logic [7:0] gain_lo;
    } cgc_cal_s;
    typedef enum logic [2:0] {
        CGC_SEL_NONE,
        CGC_SEL_OFS_HI,
        CGC_SEL_OFS_LO,
        CGC_SEL_GAIN_HI,
        CGC_SEL_GAIN_LO,
        CGC_SEL_CHECKSUM,
        CGC_SEL_RSVD
    } cgc_sel_e;
endpackage

/* File: cgc_regs.sv */
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "cgc_params.svh"
module cgc_regs #(
    parameter int ADDR_W = 6
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic [23:0] ch7_offset_cal,
    output logic [23:0] ch7_gain_cal,
    output logic [15:0] map_checksum
);
    // Bits covered by the map checksum, upper register first
    localparam int MAP_BITS = 48;

    // Offset correction, upper and lower parts
    logic [15:0] ofs_hi_ff;
    logic [15:0] nxt_ofs_hi;
    logic [7:0] ofs_lo_ff;
    logic [7:0] nxt_ofs_lo;

    // Gain correction, upper and lower parts
    logic [15:0] gain_hi_ff;
    logic [15:0] nxt_gain_hi;
    logic [7:0] gain_lo_ff;
    logic [7:0] nxt_gain_lo;

    // Whole calibration map, now and after this edge
    cgc_pkg::cgc_cal_s cal_now;
    cgc_pkg::cgc_cal_s nxt_cal;
    logic cal_changed;

    // Checksum state and the stage chain that feeds it
    logic [15:0] crc_ff;
    logic [15:0] nxt_crc;
    logic [MAP_BITS-1:0] map_bits;
    logic [15:0] crc_chain [0:MAP_BITS];
    logic [15:0] crc_result;

    // Reserved word
    logic [15:0] rsvd_ff;
    logic [15:0] nxt_rsvd;

    // Read data register
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;

    // Address decode and per-register write strobes
    cgc_pkg::cgc_sel_e wsel;
    cgc_pkg::cgc_sel_e rsel;
    logic wr_hit;
    logic wr_ofs_hi;
    logic wr_ofs_lo;
    logic wr_gain_hi;
    logic wr_gain_lo;
    logic wr_rsvd;

    // Maps a word address onto the register it selects
    function automatic cgc_pkg::cgc_sel_e decode(input logic [ADDR_W-1:0] a);
        case (a)
            `CGC_ADDR_OFS_HI: begin
                decode = cgc_pkg::CGC_SEL_OFS_HI;
            end
            `CGC_ADDR_OFS_LO: begin
                decode = cgc_pkg::CGC_SEL_OFS_LO;
            end
            `CGC_ADDR_GAIN_HI: begin
                decode = cgc_pkg::CGC_SEL_GAIN_HI;
            end
            `CGC_ADDR_GAIN_LO: begin
                decode = cgc_pkg::CGC_SEL_GAIN_LO;
            end
            `CGC_ADDR_CHECKSUM: begin
                decode = cgc_pkg::CGC_SEL_CHECKSUM;
            end
            `CGC_ADDR_RSVD: begin
                decode = cgc_pkg::CGC_SEL_RSVD;
            end
            default: begin
                decode = cgc_pkg::CGC_SEL_NONE;
            end
        endcase
    endfunction

    // Only the calibration words and the reserved word take host data;
    // the checksum and unmapped addresses refuse writes
    function automatic logic host_writable(input cgc_pkg::cgc_sel_e s);
        case (s)
            cgc_pkg::CGC_SEL_OFS_HI: begin
                host_writable = 1'b1;
            end
            cgc_pkg::CGC_SEL_OFS_LO: begin
                host_writable = 1'b1;
            end
            cgc_pkg::CGC_SEL_GAIN_HI: begin
                host_writable = 1'b1;
            end
            cgc_pkg::CGC_SEL_GAIN_LO: begin
                host_writable = 1'b1;
            end
            cgc_pkg::CGC_SEL_RSVD: begin
                host_writable = 1'b1;
            end
            cgc_pkg::CGC_SEL_CHECKSUM: begin
                host_writable = 1'b0;
            end
            default: begin
                host_writable = 1'b0;
            end
        endcase
    endfunction

    // The field of a low register sits in its upper byte
    function automatic logic [7:0] low_field(input logic [15:0] d);
        low_field = d[`CGC_LOW_FIELD_MSB:`CGC_LOW_FIELD_LSB];
    endfunction

    // Readback of a low register: field on top, read-only zeros below
    function automatic logic [15:0] low_readback(input logic [7:0] f);
        low_readback = {f, `CGC_LOW_PAD};
    endfunction

    // One shift of the checksum for one map bit
    function automatic logic [15:0] crc_step(input logic [15:0] r, input logic b);
        logic fb;
        fb = r[15] ^ b;
        crc_step = {r[14:0], 1'b0};
        if (fb) begin
            crc_step = crc_step ^ `CGC_CRC_POLY;
        end
    endfunction

    // Read and write share the address, so both decode it the same way
    assign wsel = decode(reg_addr);
    assign rsel = decode(reg_addr);
    assign wr_hit = reg_wr && host_writable(wsel);

    assign wr_ofs_hi = wr_hit && (wsel == cgc_pkg::CGC_SEL_OFS_HI);
    assign wr_ofs_lo = wr_hit && (wsel == cgc_pkg::CGC_SEL_OFS_LO);
    assign wr_gain_hi = wr_hit && (wsel == cgc_pkg::CGC_SEL_GAIN_HI);
    assign wr_gain_lo = wr_hit && (wsel == cgc_pkg::CGC_SEL_GAIN_LO);
    assign wr_rsvd = wr_hit && (wsel == cgc_pkg::CGC_SEL_RSVD);

    // Upper offset word
    always_comb begin
        nxt_ofs_hi = ofs_hi_ff;
        if (wr_ofs_hi) begin
            nxt_ofs_hi = reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ofs_hi_ff <= `CGC_RST_OFS_HI;
        end else begin
            ofs_hi_ff <= nxt_ofs_hi;
        end
    end

    // Lower offset byte; the low byte of the write is dropped
    always_comb begin
        nxt_ofs_lo = ofs_lo_ff;
        if (wr_ofs_lo) begin
            nxt_ofs_lo = low_field(reg_wdata);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ofs_lo_ff <= `CGC_RST_OFS_LO;
        end else begin
            ofs_lo_ff <= nxt_ofs_lo;
        end
    end

    // Upper gain word; resets to unity
    always_comb begin
        nxt_gain_hi = gain_hi_ff;
        if (wr_gain_hi) begin
            nxt_gain_hi = reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            gain_hi_ff <= `CGC_RST_GAIN_HI;
        end else begin
            gain_hi_ff <= nxt_gain_hi;
        end
    end

    // Lower gain byte; the low byte of the write is dropped
    always_comb begin
        nxt_gain_lo = gain_lo_ff;
        if (wr_gain_lo) begin
            nxt_gain_lo = low_field(reg_wdata);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            gain_lo_ff <= `CGC_RST_GAIN_LO;
        end else begin
            gain_lo_ff <= nxt_gain_lo;
        end
    end

    // The map as it stands and as it will stand after this edge
    assign cal_now.ofs_hi = ofs_hi_ff;
    assign cal_now.ofs_lo = ofs_lo_ff;
    assign cal_now.gain_hi = gain_hi_ff;
    assign cal_now.gain_lo = gain_lo_ff;
    assign nxt_cal.ofs_hi = nxt_ofs_hi;
    assign nxt_cal.ofs_lo = nxt_ofs_lo;
    assign nxt_cal.gain_hi = nxt_gain_hi;
    assign nxt_cal.gain_lo = nxt_gain_lo;

    // Reserved word: kept as written; the host owes it zeros
    always_comb begin
        nxt_rsvd = rsvd_ff;
        if (wr_rsvd) begin
            nxt_rsvd = reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rsvd_ff <= `CGC_RST_RSVD;
        end else begin
            rsvd_ff <= nxt_rsvd;
        end
    end

    // Checksum: the chain runs over the next map contents,
    // so the new value lands on the same edge as the write
    assign map_bits = {nxt_cal.ofs_hi, nxt_cal.ofs_lo, nxt_cal.gain_hi, nxt_cal.gain_lo};
    assign crc_chain[0] = `CGC_CRC_SEED;

    for (genvar i = 0; i < MAP_BITS; i++) begin : g_crc_stage
        assign crc_chain[i + 1] = crc_step(crc_chain[i], map_bits[MAP_BITS - 1 - i]);
    end

    assign crc_result = crc_chain[MAP_BITS];
    assign cal_changed = (nxt_cal != cal_now);

    always_comb begin
        nxt_crc = crc_ff;
        if (cal_changed) begin
            nxt_crc = crc_result;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            crc_ff <= `CGC_RST_CHECKSUM;
        end else begin
            crc_ff <= nxt_crc;
        end
    end

    // Read data: registered on the strobe, held until the next read
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            case (rsel)
                cgc_pkg::CGC_SEL_OFS_HI: begin
                    nxt_rdata = ofs_hi_ff;
                end
                cgc_pkg::CGC_SEL_OFS_LO: begin
                    nxt_rdata = low_readback(ofs_lo_ff);
                end
                cgc_pkg::CGC_SEL_GAIN_HI: begin
                    nxt_rdata = gain_hi_ff;
                end
                cgc_pkg::CGC_SEL_GAIN_LO: begin
                    nxt_rdata = low_readback(gain_lo_ff);
                end
                cgc_pkg::CGC_SEL_CHECKSUM: begin
                    nxt_rdata = crc_ff;
                end
                cgc_pkg::CGC_SEL_RSVD: begin
                    nxt_rdata = rsvd_ff;
                end
                default: begin
                    nxt_rdata = `CGC_UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdata_ff <= `CGC_RST_RDATA;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Every output is a register value, never a decode
    assign reg_rdata = rdata_ff;
    assign ch7_offset_cal = {cal_now.ofs_hi, cal_now.ofs_lo};
    assign ch7_gain_cal = {cal_now.gain_hi, cal_now.gain_lo};
    assign map_checksum = crc_ff;
endmodule // cgc_regs

/* File: cgc_regs_monitor.sv */
`timescale 1ns/100ps
module cgc_regs_monitor (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] map_checksum,
    input wire logic [23:0] ch7_offset_cal,
    input wire logic [23:0] ch7_gain_cal
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_ofs_hi_wr: assert property (reg_wr && reg_addr == 6'h2D
        |=> ch7_offset_cal[23:8] == $past(reg_wdata)) else $error("offset high");
    chk_ofs_lo_wr: assert property (reg_wr && reg_addr == 6'h2E
        |=> ch7_offset_cal[7:0] == $past(reg_wdata[15:8])) else $error("offset low");
    chk_gain_hi_wr: assert property (reg_wr && reg_addr == 6'h2F
        |=> ch7_gain_cal[23:8] == $past(reg_wdata)) else $error("gain high");
    chk_gain_lo_wr: assert property (reg_wr && reg_addr == 6'h30
        |=> ch7_gain_cal[7:0] == $past(reg_wdata[15:8])) else $error("gain low");
    chk_gain_unity: assert property (disable iff (1'b0) !reset_n
        |=> ch7_gain_cal == 24'h800000) else $error("gain reset");
    chk_sum_ro: assert property (reg_wr && reg_addr == 6'h3E
        |=> $stable(map_checksum)) else $error("checksum written");
    chk_low_zero: assert property (reg_rd && reg_addr inside {6'h2E, 6'h30}
        |=> reg_rdata[7:0] == 8'h00) else $error("low byte not zero");
    chk_sum_track: assert property ($changed({ch7_offset_cal, ch7_gain_cal})
        |-> $changed(map_checksum)) else $error("checksum stale");
    cover property (reg_wr && reg_addr == 6'h2F);
    cover property (reg_rd && reg_addr == 6'h3E);
    cover property (reg_wr && reg_addr == 6'h3F);
endmodule // cgc_regs_monitor
bind cgc_regs cgc_regs_monitor cgc_regs_monitor_i (.*);

/* File: testbench.sv */
`timescale 1ns/100ps
`include "cgc_params.svh"
module testbench;
    logic sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, map_checksum;
    logic [23:0] ch7_offset_cal, ch7_gain_cal;
    int num_errors = 0, cmp_count = 0;
    // Address, write data, expected readback
    logic [37:0] rows [7] = '{{6'h3E, 16'h1234, 16'h0000}, {6'h10, 16'hFFFF, 16'h0000},
        {6'h2D, 16'h8123, 16'h8123}, {6'h2E, 16'hABCD, 16'hAB00},
        {6'h2F, 16'hFFFF, 16'hFFFF}, {6'h30, 16'h5A5A, 16'h5A00}, {6'h3F, 16'h0000, 16'h0000}};
    always #5 sys_clk = ~sys_clk;
    cgc_regs cgc_regs_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ch7_offset_cal(ch7_offset_cal), .ch7_gain_cal(ch7_gain_cal), .map_checksum(map_checksum));
    task automatic op(input logic w, r, input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic check(input logic [23:0] g, e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Reference checksum over the 48 covered bits, most significant first
    function automatic logic [15:0] ref_crc(input logic [47:0] m);
        logic [15:0] r;
        r = `CGC_CRC_SEED;
        for (int i = 47; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ m[i]) ? `CGC_CRC_POLY : 16'h0000);
        end
        return r;
    endfunction
    task finish_test;
        if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        check(ch7_gain_cal, 24'h800000);
        check(ch7_offset_cal, 24'h000000);
        op(1'b0, 1'b1, 6'h2F, 16'h0000);
        check(reg_rdata, 16'h8000);
        foreach (rows[i]) begin
            op(1'b1, 1'b0, rows[i][37:32], rows[i][31:16]);
            op(1'b0, 1'b1, rows[i][37:32], 16'h0000);
            check(reg_rdata, rows[i][15:0]);
        end
        check(ch7_offset_cal, 24'h8123AB);
        check(ch7_gain_cal, 24'hFFFF5A);
        check(map_checksum, ref_crc(48'h8123ABFFFF5A));
        op(1'b1, 1'b0, 6'h3E, 16'h1234);
        op(1'b0, 1'b1, 6'h3E, 16'h0000);
        check(reg_rdata, ref_crc(48'h8123ABFFFF5A));
        @(posedge sys_clk);
        reset_n <= 1'b0;
        @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        check({ch7_offset_cal[7:0], map_checksum}, 24'h000000);
        check(ch7_gain_cal, 24'h800000);
        finish_test();
    end
endmodule // testbench
